// ### bscc_chain_seg.sv
// Boundary scan cells 0..56: aux port, receive outputs, acknowledge
// Operation
// - Direction cell 0 drives aux pins from cells
// - Direction cell 1 floats aux pins, captures inputs
// - Cell 23 enables or floats channel 1 receive
// - Cell 31 enables or floats channel 0 receive
// - Cell 37 enables or floats channel 3 receive
// - Cell 45 enables or floats channel 2 receive
// - Cell 52 enables or floats acknowledge output
// - 98-bit chain, accessed under extest or sample
// - Cells 0..15 alternate aux output, input
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bscc_chain_seg import bscc_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic               tck,
  input  wire logic               tap_capture_dr,
  input  wire logic               tap_shift_dr,
  input  wire logic               tap_update_dr,
  input  wire logic               instr_extest,
  input  wire logic               instr_sample_preload,
  input  wire logic               scan_in,
  output logic                    scan_out,
  input  wire logic [SENSE_N-1:0] cell_sense,
  input  wire logic [AUX_N-1:0]   func_aux_out,
  input  wire logic [AUX_N-1:0]   func_aux_oe_n,
  input  wire logic [AUX_N-1:0]   aux_port_pins_in,
  output logic [AUX_N-1:0]        aux_port_pins_out,
  output logic [AUX_N-1:0]        aux_port_pins_oe_n,
  input  wire logic [RX_N-1:0]    func_rx_clk,
  input  wire logic [RX_N-1:0]    func_rx_dp,
  input  wire logic [RX_N-1:0]    func_rx_dn,
  input  wire logic [RX_N-1:0]    func_rx_oe_n,
  input  wire logic [RX_N-1:0]    func_los,
  output logic [RX_N-1:0]         rx_clk_out,
  output logic [RX_N-1:0]         rx_data_positive,
  output logic [RX_N-1:0]         rx_data_negative,
  output logic [RX_N-1:0]         rx_oe_n,
  output logic [RX_N-1:0]         los_out,
  input  wire logic               func_int,
  output logic                    int_out,
  input  wire logic               func_ack,
  input  wire logic               func_ack_oe_n,
  output logic                    ack_out,
  output logic                    ack_oe_n,
  input  wire logic [ADDR_W-1:0]  s_axil_awaddr,
  input  wire logic               s_axil_awvalid,
  output logic                    s_axil_awready,
  input  wire logic [31:0]        s_axil_wdata,
  input  wire logic [3:0]         s_axil_wstrb,
  input  wire logic               s_axil_wvalid,
  output logic                    s_axil_wready,
  output logic [1:0]              s_axil_bresp,
  output logic                    s_axil_bvalid,
  input  wire logic               s_axil_bready,
  input  wire logic [ADDR_W-1:0]  s_axil_araddr,
  input  wire logic               s_axil_arvalid,
  output logic                    s_axil_arready,
  output logic [31:0]             s_axil_rdata,
  output logic [1:0]              s_axil_rresp,
  output logic                    s_axil_rvalid,
  input  wire logic               s_axil_rready
);

  // ---- Test clock domain ----

  bscc_cells_t      chain_q;     // Shift stage of the cells
  bscc_cells_t      upd_q;       // Update stage, drives pins in extest
  bscc_cells_t      cap_d;       // Parallel capture image
  logic [RAW_N-1:0] raw_s1_q;    // Pin sense synchroniser, stage 1
  logic [RAW_N-1:0] raw_s2_q;    // Stage 2
  logic [RAW_N-1:0] raw_s3_q;    // Stage 3
  logic [RAW_N-1:0] raw_f_q;     // Accepted pin levels
  logic [RAW_N-1:0] raw_agree;   // Stages 2 and 3 match
  logic [AUX_N-1:0] aux_filt;    // Accepted aux pin levels
  logic [AUX_N-1:0] aux_drv;     // Value offered to aux pins
  logic             sel;         // Boundary register is on the scan path
  logic             ext;         // Pins follow the update stage
  logic [IMG_W-1:0] img_hold_q;  // Control image parked for mclk
  logic [IMG_W-1:0] img_d;
  logic             tog_q;       // Flips on every update event while selected

  bscc_reg_if rif ();            // Link to the register slave

  // Only these two instructions put the segment on the scan path
  assign sel = instr_extest || instr_sample_preload;
  // Sample/preload keeps the functional path; only extest hands over
  assign ext = instr_extest;

  // Pins sampled asynchronously to tck pass three flops; a bit is
  // taken only once stages 2 and 3 agree, which filters a single
  // metastable resolution at the cost of two tck of latency
  always_ff @(posedge tck or negedge resetn)
    if (!resetn)
    begin
      raw_s1_q <= '0;
      raw_s2_q <= '0;
      raw_s3_q <= '0;
    end
    else
    begin
      raw_s1_q <= {cell_sense, aux_port_pins_in};
      raw_s2_q <= raw_s1_q;
      raw_s3_q <= raw_s2_q;
    end

  assign raw_agree = ~(raw_s2_q ^ raw_s3_q);

  // Accepted levels update per bit while the two stages agree
  always_ff @(posedge tck or negedge resetn)
    if (!resetn)
      raw_f_q <= '0;
    else
      raw_f_q <= (raw_agree & raw_s2_q) | (~raw_agree & raw_f_q);

  assign aux_filt = raw_f_q[AUX_N-1:0];

  // Aux port cells: output cell at even, input cell at odd position
  for (genvar i = 0; i < AUX_N; i++)
  begin : g_aux
    assign aux_drv[i]      = ext ? upd_q[2*i] : func_aux_out[i];
    assign cap_d[2*i]      = aux_drv[i];
    assign cap_d[2*i+1]    = aux_filt[i];
  end
  // Cells 16..56 capture their pin or core sense line
  assign cap_d[SEG_LEN-1:SENSE_LO] = raw_f_q[RAW_N-1:AUX_N];

  // Capture, shift toward cell 0, or hold; idle when not selected
  always_ff @(posedge tck or negedge resetn)
    if (!resetn)
      chain_q <= '0;
    else if (sel && tap_capture_dr)
      chain_q <= cap_d;
    else if (sel && tap_shift_dr)
      chain_q <= {scan_in, chain_q[SEG_LEN-1:1]};
    else
      chain_q <= chain_q;

  // Cell 0 leaves toward the test data output
  assign scan_out = chain_q[0];

  // Update stage loads under either instruction so preload works,
  // but only extest lets it reach the pins
  always_ff @(posedge tck or negedge resetn)
    if (!resetn)
      upd_q <= UPD_RST;
    else if (sel && tap_update_dr)
      upd_q <= chain_q;

  // Control image for software, gathered from the update source
  always_comb
  begin
    img_d          = '0;
    img_d[IMG_DIR] = chain_q[POS_DIR];
    for (int c = 0; c < RX_N; c++)
      img_d[IMG_HIZ+c] = chain_q[POS_HIZ[c]];
    img_d[IMG_ACKZ] = chain_q[POS_ACKZ];
  end

  // Image is parked with a toggle; it stays still for many mclk
  // cycles because updates are at least several tck apart
  always_ff @(posedge tck or negedge resetn)
    if (!resetn)
    begin
      img_hold_q <= '0;
      tog_q      <= 1'b0;
    end
    else if (sel && tap_update_dr)
    begin
      img_hold_q <= img_d;
      tog_q      <= ~tog_q;
    end

  // ---- Pin multiplexers ----

  // Direction cell: 0 drives all aux pins, 1 releases them
  assign aux_port_pins_out  = aux_drv;
  assign aux_port_pins_oe_n = ext ? {AUX_N{upd_q[POS_DIR]}}
                                  : (func_aux_oe_n | {AUX_N{rif.func_hiz}});

  // Receive outputs per channel; one control cell governs clock and
  // both data pins of its channel
  for (genvar c = 0; c < RX_N; c++)
  begin : g_rx
    assign rx_clk_out[c]       = ext ? upd_q[POS_RCLK[c]] : func_rx_clk[c];
    assign rx_data_positive[c] = ext ? upd_q[POS_RDP[c]] : func_rx_dp[c];
    assign rx_data_negative[c] = ext ? upd_q[POS_RDN[c]] : func_rx_dn[c];
    assign rx_oe_n[c]          = ext ? upd_q[POS_HIZ[c]]
                                     : (func_rx_oe_n[c] | rif.func_hiz);
    assign los_out[c]          = ext ? upd_q[POS_LOS[c]] : func_los[c];
  end

  // Interrupt has no control cell and is always driven
  assign int_out  = ext ? upd_q[POS_INT] : func_int;
  // Acknowledge pin with its own high-Z control
  assign ack_out  = ext ? upd_q[POS_ACK] : func_ack;
  assign ack_oe_n = ext ? upd_q[POS_ACKZ]
                        : (func_ack_oe_n | rif.func_hiz);

  // ---- Master clock domain ----

  logic [2:0]       tog_sync_q;  // Toggle synchroniser
  logic             tog_acc_q;   // Accepted toggle level
  logic [2:0]       ext_sync_q;  // Extest level synchroniser
  logic             ext_acc_q;   // Accepted extest level
  logic [IMG_W-1:0] img_q;       // Image as seen by software
  logic [CNT_W-1:0] cnt_q;       // Update events counted
  logic             tog_new;     // Fresh update event seen

  // Three-flop synchronisers; stage 1 feeds stage 2 only
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      tog_sync_q <= '0;
      ext_sync_q <= '0;
    end
    else
    begin
      tog_sync_q <= {tog_sync_q[1:0], tog_q};
      ext_sync_q <= {ext_sync_q[1:0], instr_extest};
    end

  // An event counts once stages 2 and 3 agree on a new level
  assign tog_new = (tog_sync_q[1] == tog_sync_q[2]) &&
                   (tog_sync_q[2] != tog_acc_q);

  // Toggle acceptance and image capture
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      tog_acc_q <= 1'b0;
      img_q     <= '0;
    end
    else if (tog_new)
    begin
      tog_acc_q <= tog_sync_q[2];
      img_q     <= img_hold_q;
    end

  // Count of update events, wraps silently
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      cnt_q <= '0;
    else if (tog_new)
      cnt_q <= cnt_q + 1'b1;

  // Extest level filtered the same way
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      ext_acc_q <= 1'b0;
    else if (ext_sync_q[1] == ext_sync_q[2])
      ext_acc_q <= ext_sync_q[2];

  assign rif.ext_seen = ext_acc_q;
  assign rif.ctl_img  = img_q;
  assign rif.upd_cnt  = cnt_q;

  // Register slave on AXI4-Lite
  bscc_axil_regs u_regs (
    .mclk           (mclk),
    .resetn         (resetn),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .rif            (rif.regs)
  );

  // ---- Checks in the test clock domain ----

  // Loading 0 into the direction cell under extest drives the pins
  AST_DIR_DRIVE: assert property (@(posedge tck) disable iff (!resetn)
    (tap_update_dr && instr_extest && !chain_q[POS_DIR])
      |=> (!instr_extest || (aux_port_pins_oe_n == '0
           && aux_port_pins_out[0] == $past(chain_q[0]))))
    else $error("aux pins not driven from output cells");

  // Capture under extest takes the filtered aux input level
  AST_DIR_CAPTURE: assert property (@(posedge tck) disable iff (!resetn)
    (tap_capture_dr && instr_extest)
      |=> chain_q[1] == $past(aux_filt[0]) && chain_q[15] == $past(aux_filt[7]))
    else $error("aux input cells missed pin level");

  AST_RX1_HIZ: assert property (@(posedge tck) disable iff (!resetn)
    (tap_update_dr && instr_extest)
      |=> (!instr_extest || rx_oe_n[1] == $past(chain_q[23])))
    else $error("channel 1 receive enable wrong");

  AST_RX0_HIZ: assert property (@(posedge tck) disable iff (!resetn)
    (tap_update_dr && instr_extest)
      |=> (!instr_extest || rx_oe_n[0] == $past(chain_q[31])))
    else $error("channel 0 receive enable wrong");

  AST_RX3_HIZ: assert property (@(posedge tck) disable iff (!resetn)
    (tap_update_dr && instr_extest)
      |=> (!instr_extest || rx_oe_n[3] == $past(chain_q[37])))
    else $error("channel 3 receive enable wrong");

  AST_RX2_HIZ: assert property (@(posedge tck) disable iff (!resetn)
    (tap_update_dr && instr_extest)
      |=> (!instr_extest || rx_oe_n[2] == $past(chain_q[45])))
    else $error("channel 2 receive enable wrong");

  AST_ACK_HIZ: assert property (@(posedge tck) disable iff (!resetn)
    (tap_update_dr && instr_extest)
      |=> (!instr_extest || ack_oe_n == $past(chain_q[52])))
    else $error("acknowledge enable wrong");

  // Shifting moves one cell toward the output each tck
  AST_SHIFT: assert property (@(posedge tck) disable iff (!resetn)
    (tap_shift_dr && sel && !tap_capture_dr)
      |=> chain_q[SEG_LEN-1] == $past(scan_in) && scan_out == $past(chain_q[1]))
    else $error("segment shift broken");

  // Output cell 0 captures the value offered to aux pin 0
  AST_AUX_PAIR: assert property (@(posedge tck) disable iff (!resetn)
    (tap_capture_dr && sel) |=> chain_q[0] == $past(aux_drv[0]))
    else $error("aux output cell capture wrong");

  // Without a selecting instruction the update stage never moves
  AST_NO_UPDATE: assert property (@(posedge tck) disable iff (!resetn)
    (tap_update_dr && !sel) |=> upd_q == $past(upd_q))
    else $error("update stage changed while deselected");

endmodule
`default_nettype wire

// ### bscc_pkg.sv
// Shared constants and types for the boundary scan cell segment
package bscc_pkg;

  // Chain geometry
  localparam int CHAIN_LEN = 98;            // Whole device chain length
  localparam int SEG_LEN   = 57;            // Cells 0..56 live in this block
  localparam int AUX_N     = 8;             // Auxiliary port pins
  localparam int RX_N      = 4;             // Receive channels 0..3
  localparam int SENSE_LO  = 16;            // First cell fed by a sense input
  localparam int SENSE_N   = SEG_LEN - SENSE_LO;
  localparam int RAW_N     = SENSE_N + AUX_N;

  // Fixed cell positions
  localparam int POS_DIR   = 16;            // Aux port direction control
  localparam int POS_INT   = 50;            // Interrupt output cell
  localparam int POS_ACK   = 51;            // Acknowledge output cell
  localparam int POS_ACKZ  = 52;            // Acknowledge high-Z control

  // Per-channel positions, index is the channel number
  typedef int bscc_pos_t [RX_N];
  localparam bscc_pos_t POS_HIZ  = '{31, 23, 45, 37};
  localparam bscc_pos_t POS_RCLK = '{28, 20, 46, 38};
  localparam bscc_pos_t POS_RDP  = '{29, 21, 44, 36};
  localparam bscc_pos_t POS_RDN  = '{30, 22, 43, 35};
  localparam bscc_pos_t POS_LOS  = '{32, 24, 42, 34};

  typedef logic [SEG_LEN-1:0] bscc_cells_t;

  // Control cells reset to 1 so every governed pin starts released
  function automatic bscc_cells_t bscc_ctrl_mask();
    bscc_cells_t m;
    m = '0;
    m[POS_DIR]  = 1'b1;
    m[POS_ACKZ] = 1'b1;
    for (int c = 0; c < RX_N; c++)
      m[POS_HIZ[c]] = 1'b1;
    return m;
  endfunction
  localparam bscc_cells_t UPD_RST = bscc_ctrl_mask();

  // Control image seen by software
  localparam int IMG_W    = 6;
  localparam int IMG_DIR  = 0;              // Direction cell
  localparam int IMG_HIZ  = 1;              // Channel 0..3 high-Z cells
  localparam int IMG_ACKZ = 5;              // Acknowledge high-Z cell
  localparam int CNT_W    = 16;             // Update event counter width

  // AXI4-Lite register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAT   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CELLS  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_UPDCNT = 8'h0c;
  localparam int CTRL_HIZ_BIT = 0;          // Float functional drivers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ### bscc_reg_if.sv
// Carrier between the scan segment core and its register slave
`timescale 1ns/1ps
`default_nettype none
interface bscc_reg_if import bscc_pkg::*; ();
  logic             func_hiz;   // Software forces functional drivers off
  logic             ext_seen;   // Extest selected, in mclk domain
  logic [IMG_W-1:0] ctl_img;    // Last updated control cells
  logic [CNT_W-1:0] upd_cnt;    // Update events seen
  modport regs (output func_hiz, input ext_seen, ctl_img, upd_cnt);
  modport core (input func_hiz, output ext_seen, ctl_img, upd_cnt);
endinterface
`default_nettype wire

// ### bscc_axil_regs.sv
// AXI4-Lite register slave for the boundary scan cell segment
`timescale 1ns/1ps
`default_nettype none
module bscc_axil_regs import bscc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  output logic [31:0]            s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  bscc_reg_if.regs               rif
);

  logic              aw_full_q;   // Write address held
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_full_q;    // Write data held
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              hiz_q;       // Functional float control
  logic              do_wr;

  // Address decode shared by both directions
  function automatic logic bscc_mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_STAT) ||
           (a == REG_CELLS) || (a == REG_UPDCNT);
  endfunction

  // Read word selection; unmapped reads return zero
  function automatic logic [31:0] bscc_rd_word(input logic [ADDR_W-1:0] a);
    case (a)
      REG_CTRL:   return 32'(hiz_q);
      REG_STAT:   return 32'(rif.ext_seen);
      REG_CELLS:  return 32'(rif.ctl_img);
      REG_UPDCNT: return 32'(rif.upd_cnt);
      default:    return 32'h0000_0000;
    endcase
  endfunction

  // Each holding slot accepts only when empty, so order is free
  assign s_axil_awready = !aw_full_q;
  assign s_axil_wready  = !w_full_q;
  assign s_axil_arready = !rvalid_q;
  assign do_wr          = aw_full_q && w_full_q && !bvalid_q;

  // Write address slot
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (s_axil_awvalid && !aw_full_q)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axil_awaddr;
    end
    else if (do_wr)
      aw_full_q <= 1'b0;

  // Write data slot
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (s_axil_wvalid && !w_full_q)
    begin
      w_full_q <= 1'b1;
      w_data_q <= s_axil_wdata;
      w_strb_q <= s_axil_wstrb;
    end
    else if (do_wr)
      w_full_q <= 1'b0;

  // Write response, one cycle after both halves are held
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= bscc_mapped(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axil_bready)
      bvalid_q <= 1'b0;

  // Control register; only byte lane 0 carries a bit
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      hiz_q <= 1'b0;
    else if (do_wr && aw_addr_q == REG_CTRL && w_strb_q[0])
      hiz_q <= w_data_q[CTRL_HIZ_BIT];

  // Read channel, answered the cycle after the address is taken
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (s_axil_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= bscc_rd_word(s_axil_araddr);
      rresp_q  <= bscc_mapped(s_axil_araddr) ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axil_rready)
      rvalid_q <= 1'b0;

  assign s_axil_bvalid = bvalid_q;
  assign s_axil_bresp  = bresp_q;
  assign s_axil_rvalid = rvalid_q;
  assign s_axil_rdata  = rdata_q;
  assign s_axil_rresp  = rresp_q;
  assign rif.func_hiz  = hiz_q;

endmodule
`default_nettype wire

// ### bscc_jtag_model.sv
// Board test controller model driving the scan segment from the link side
`timescale 1ns/1ps
`default_nettype none
module bscc_jtag_model import bscc_pkg::*;
(
  input  wire logic tck,
  input  wire logic scan_out,
  output var logic  cap,
  output var logic  sft,
  output var logic  upd,
  output var logic  ext,
  output var logic  smp,
  output var logic  sdi
);
  initial {cap, sft, upd, ext, smp, sdi} = 6'h00;
  // Whole access: select, capture, one shift per cell, update
  task automatic scan(input logic e, s, input bscc_cells_t v, output bscc_cells_t q);
    @(posedge tck);
    {ext, smp, cap} <= {e, s, 1'b1};
    @(posedge tck);
    {cap, sft, sdi} <= {1'b0, 1'b1, v[0]};
    for (int k = 0; k < SEG_LEN; k++)
    begin
      @(negedge tck);
      q[k] = scan_out;
      @(posedge tck);
      // Past the last bit the line shows the inverse, never a stale copy
      sdi <= (k < SEG_LEN - 1) ? v[k + 1] : ~v[k];
    end
    {sft, upd} <= 2'b01;
    @(posedge tck);
    upd <= 1'b0;
    @(negedge tck);
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the scan cell segment and its register slave
`timescale 1ns/1ps
`default_nettype none
module tb import bscc_pkg::*; ();
  logic mclk = 0, tck = 0, resetn = 0, cap, sft, upd, ext, smp, sdi, sdo, intp, ack, ackz;
  logic [SENSE_N-1:0] sense = 41'h1a5c3f00f96;
  logic [7:0] ain = 8'h96, fo = 8'h5a, fe = 8'h3c, ao, ae, aw = 8'h00, ar = 8'h00;
  logic [3:0] fc = 4'h9, fp = 4'h3, fn = 4'hc, fz = 4'h6, fl = 4'ha, rc, rp, rn, rz, ls, ws = 4'h0;
  logic fi = 1'b1, fa = 1'b0, faz = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr_, bv, arr, rv;
  logic [31:0] wd = 32'h0, rdt, d, c0;
  logic [1:0] brs, rrs, r;
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #5 mclk = ~mclk;
  // Offset keeps link edges off the mclk edges
  initial #3 forever #15 tck = ~tck;
  bscc_jtag_model m (.tck(tck), .scan_out(sdo), .cap(cap), .sft(sft), .upd(upd), .ext(ext), .smp(smp), .sdi(sdi));
  bscc_chain_seg dut (.mclk(mclk), .resetn(resetn), .tck(tck), .tap_capture_dr(cap), .tap_shift_dr(sft),
    .tap_update_dr(upd), .instr_extest(ext), .instr_sample_preload(smp), .scan_in(sdi), .scan_out(sdo),
    .cell_sense(sense), .func_aux_out(fo), .func_aux_oe_n(fe), .aux_port_pins_in(ain), .aux_port_pins_out(ao),
    .aux_port_pins_oe_n(ae), .func_rx_clk(fc), .func_rx_dp(fp), .func_rx_dn(fn), .func_rx_oe_n(fz),
    .func_los(fl), .rx_clk_out(rc), .rx_data_positive(rp), .rx_data_negative(rn), .rx_oe_n(rz), .los_out(ls),
    .func_int(fi), .int_out(intp), .func_ack(fa), .func_ack_oe_n(faz), .ack_out(ack), .ack_oe_n(ackz),
    .s_axil_awaddr(aw), .s_axil_awvalid(awv), .s_axil_awready(awr), .s_axil_wdata(wd), .s_axil_wstrb(ws),
    .s_axil_wvalid(wv), .s_axil_wready(wr_), .s_axil_bresp(brs), .s_axil_bvalid(bv), .s_axil_bready(br),
    .s_axil_araddr(ar), .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_rdata(rdt), .s_axil_rresp(rrs),
    .s_axil_rvalid(rv), .s_axil_rready(rr));
  task automatic chk(input logic [63:0] g, e, input string s);
    comparisons++;
    n_fail += int'(g !== e);
    if (g !== e) $display("BAD %0t %s", $time, s);
  endtask
  // One write or read; ready is judged at the falling edge, acted on at the rising one
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
    logic ta, tw, tr;
    @(posedge mclk);
    if (w) {aw, wd, ws, awv, wv, br} <= {a, x, 4'hf, 3'b111};
    else {ar, arv, rr} <= {a, 2'b11};
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge mclk);
      {ta, tw, tr, r, d} = {awv & awr | arv & arr, wv & wr_, bv | rv, w ? brs : rrs, rdt};
      @(posedge mclk);
      if (ta) {awv, arv} <= 2'b00;
      if (tw) wv <= 1'b0;
    end
    {br, rr} <= 2'b00;
  endtask
  task automatic s_regs();
    bus(1'b1, REG_CTRL, 32'h1);
    chk({r, ae}, {RESP_OKAY, 8'hff}, "float");
    bus(1'b0, REG_CTRL, 32'h0);
    chk({r, d[0]}, {RESP_OKAY, 1'b1}, "ctrl");
    bus(1'b1, REG_CTRL, 32'h0);
    chk(ae, fe, "func oe");
    bus(1'b0, 8'h10, 32'h0);
    chk({r, d}, {RESP_DECERR, 32'h0}, "unmapped rd");
    bus(1'b1, 8'h10, 32'h1);
    chk(r, RESP_DECERR, "unmapped wr");
  endtask
  // Preload leaves the functional drivers in charge
  task automatic s_preload();
    bscc_cells_t q;
    bus(1'b0, REG_UPDCNT, 32'h0);
    c0 = d;
    m.scan(1'b0, 1'b1, '0, q);
    for (int i = 0; i < AUX_N; i++)
      chk(q[2*i+1], ain[i], "aux in");
    chk(q[SEG_LEN-1:SENSE_LO], sense, "sense");
    chk({ae, rz, ackz, intp, ls}, {fe, fz, faz, fi, fl}, "func pins");
    repeat (8) @(posedge mclk);
    bus(1'b0, REG_UPDCNT, 32'h0);
    chk(d, c0 + 32'h1, "count");
    // With neither instruction selected, shift and update are ignored
    m.scan(1'b0, 1'b0, '1, q);
    chk({sdo, q}, '0, "deselected shift");
    repeat (8) @(posedge mclk);
    bus(1'b0, REG_UPDCNT, 32'h0);
    chk(d, c0 + 32'h1, "deselected update");
  endtask
  // Each pass enables one control cell only
  task automatic s_extest();
    bscc_cells_t v, q;
    for (int i = 0; i < 6; i++)
    begin
      v = 57'h0a55a3c96f0c3a5 | UPD_RST;
      v[i < RX_N ? POS_HIZ[i % RX_N] : i == 4 ? POS_DIR : POS_ACKZ] = 1'b0;
      m.scan(1'b1, 1'b0, v, q);
      chk(rz, 4'(~(4'h1 << i)), "rx oe");
      if (i < RX_N) chk({rc[i], rp[i], rn[i]}, {v[POS_RCLK[i]], v[POS_RDP[i]], v[POS_RDN[i]]}, "rx");
      chk({ae, ackz}, {{AUX_N{v[POS_DIR]}}, v[POS_ACKZ]}, "oe");
      if (i == 4) chk(ao, {v[14], v[12], v[10], v[8], v[6], v[4], v[2], v[0]}, "aux");
      if (i == 5) chk(ack, v[POS_ACK], "ack");
      repeat (8) @(posedge mclk);
      bus(1'b0, REG_CELLS, 32'h0);
      chk(d[5:0], {v[52], v[37], v[45], v[23], v[31], v[16]}, "image");
    end
    bus(1'b0, REG_STAT, 32'h0);
    chk(d[0], 1'b1, "extest seen");
  endtask
  task automatic report_and_stop(input int late = 0);
    n_fail += late;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    s_regs();
    s_preload();
    s_extest();
    report_and_stop();
  end
  // Hang guard, far beyond the under two thousand cycles the run needs
  always @(posedge mclk) if (++cyc == 30000) report_and_stop(1);
endmodule
`default_nettype wire
